// [ddc_pkg.sv]
package ddc_pkg;
  localparam int SAMPLE_W       = 8;
  localparam int NCO_W          = 8;
  localparam int PHASE_W        = 32;
  localparam int ACC_W          = 24;
  localparam int DEC_W          = 6;
  localparam int DEC_LSB        = 0;
  localparam int DEC_MSB        = 5;
  localparam int DEC_MIN        = 2;
  localparam int DEC_MAX        = 64;
  localparam int FIFO_DEPTH     = 16;
  localparam logic [7:0] RX_DEC_REG_ADDR = 8'h02;
  localparam logic [DEC_W-1:0] DEC_RESET = 6'h02;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 32'h00000000;

  typedef enum logic {ddc_direct_if, ddc_quadrature} ddc_mode_e;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } ddc_sample_s;

  typedef struct packed {
    logic signed [ACC_W-1:0] i;
    logic signed [ACC_W-1:0] q;
  } ddc_bb_s;
endpackage : ddc_pkg

// [ddc_fifo.sv]
`timescale 1ns/1ps
module ddc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : ddc_fifo

// [ddc_downconverter.sv]
// Contract
// - direct IF mode uses only two multiplier products: real-input mixing
// - quadrature mode uses full four-product complex multiply of I and Q
// - NCO gives sine and cosine at minus IF, mixing the signal to baseband
// - integrate-and-dump sums N mixed samples, outputs once, restarts
// - integrate-and-dump is the lowpass filter that suppresses the image
// - decimation count from six-bit field, two to sixty-four clocks
`timescale 1ns/1ps
module ddc_downconverter #(
  parameter int FIFO_DEPTH = ddc_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire ddc_pkg::ddc_mode_e            mode,
  input  wire logic [ddc_pkg::DEC_W-1:0]     decim_count,
  input  wire logic [ddc_pkg::PHASE_W-1:0]   phase_step,
  input  wire logic [ddc_pkg::SAMPLE_W-1:0]  if_sample_in_i,
  input  wire logic [ddc_pkg::SAMPLE_W-1:0]  if_sample_in_q,
  input  wire logic                          zero_is_offset_binary,
  output logic                               stall,
  output logic                               baseband_sample_strobe,
  input  wire logic                          baseband_ready,
  output ddc_pkg::ddc_bb_s                   baseband_sample
);
  localparam int SW = ddc_pkg::SAMPLE_W;
  localparam int NW = ddc_pkg::NCO_W;
  localparam int AW = ddc_pkg::ACC_W;
  localparam int PW = 2 * SW + 1;
  localparam logic [SW-1:0] ZERO_FLIP = {1'b1, {(SW-1){1'b0}}};

  ddc_pkg::ddc_sample_s        in_reg;
  ddc_pkg::ddc_sample_s        in_signed;
  logic [SW-1:0]               fmt_flip;
  logic [ddc_pkg::PHASE_W-1:0] phase;
  logic [5:0]                  lut_sin_addr;
  logic [5:0]                  lut_cos_addr;
  logic signed [NW-1:0]        lo_cos;
  logic signed [NW-1:0]        lo_sin;
  logic signed [PW-1:0]        prod_ic;
  logic signed [PW-1:0]        prod_is;
  logic signed [PW-1:0]        prod_qc;
  logic signed [PW-1:0]        prod_qs;
  logic signed [PW-1:0]        mix [2];
  logic signed [AW-1:0]        total [2];
  logic [6:0]                  dec_cnt;
  logic [6:0]                  dec_len;
  logic                        dump;
  logic                        fifo_ready;
  ddc_pkg::ddc_bb_s            dump_data;
  ddc_pkg::ddc_bb_s            fifo_out;
  logic                        fifo_valid;
  logic                        run;

  // a field of zero stands for the top count
  always_comb begin
    if (decim_count == '0) begin
      dec_len = 7'(ddc_pkg::DEC_MAX);
    end else if (decim_count < 6'(ddc_pkg::DEC_MIN)) begin
      dec_len = 7'(ddc_pkg::DEC_MIN);
    end else begin
      dec_len = {1'b0, decim_count};
    end
  end

  // input, phase, counter and sums hold while a dump waits for room; the output side keeps draining
  assign run   = ce && !stall;
  assign stall = dump && !fifo_ready;

  // input capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_reg <= '0;
    end else if (run) begin
      in_reg.i <= if_sample_in_i;
      in_reg.q <= if_sample_in_q;
    end
  end

  // offset-binary samples recoded to two's complement
  assign fmt_flip = zero_is_offset_binary ? ZERO_FLIP : '0;

  always_comb begin
    in_signed.i = in_reg.i ^ fmt_flip;
    in_signed.q = in_reg.q ^ fmt_flip;
  end

  // phase accumulator; step programmed as minus the IF
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= ddc_pkg::PHASE_RESET;
    end else if (run) begin
      phase <= phase + phase_step;
    end
  end

  // quarter-wave-symmetric 16-entry sine table per quadrant
  function automatic logic signed [NW-1:0] sin_lut(input logic [5:0] p);
    logic [3:0] idx;
    logic [6:0] mag;
    idx = p[4] ? ~p[3:0] : p[3:0];
    case (idx)
      4'h0: mag = 7'h06;
      4'h1: mag = 7'h12;
      4'h2: mag = 7'h1F;
      4'h3: mag = 7'h2B;
      4'h4: mag = 7'h36;
      4'h5: mag = 7'h41;
      4'h6: mag = 7'h4B;
      4'h7: mag = 7'h55;
      4'h8: mag = 7'h5D;
      4'h9: mag = 7'h65;
      4'hA: mag = 7'h6B;
      4'hB: mag = 7'h71;
      4'hC: mag = 7'h75;
      4'hD: mag = 7'h79;
      4'hE: mag = 7'h7B;
      4'hF: mag = 7'h7E;
      default: mag = 7'h00;
    endcase
    return p[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sin_lut

  // table addresses: top phase bits, cosine a quarter turn ahead
  assign lut_sin_addr = phase[ddc_pkg::PHASE_W-1 -: 6];
  assign lut_cos_addr = lut_sin_addr + 6'h10;
  assign lo_sin       = sin_lut(lut_sin_addr);
  assign lo_cos       = sin_lut(lut_cos_addr);

  // four products of (i + jq)(cos + j sin); direct IF keeps the two on i
  always_comb begin
    prod_ic = PW'(in_signed.i * lo_cos);
    prod_is = PW'(in_signed.i * lo_sin);
    prod_qc = '0;
    prod_qs = '0;
    if (mode == ddc_pkg::ddc_quadrature) begin
      prod_qc = PW'(in_signed.q * lo_cos);
      prod_qs = PW'(in_signed.q * lo_sin);
    end
  end

  always_comb begin
    mix[0] = prod_ic - prod_qs;
    mix[1] = prod_is + prod_qc;
  end

  assign dump = (dec_cnt >= dec_len - 7'h01);

  // interval counter, dumps on the Nth accepted sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_cnt <= '0;
    end else if (run) begin
      if (dump) begin
        dec_cnt <= '0;
      end else begin
        dec_cnt <= dec_cnt + 7'h01;
      end
    end
  end

  // integrate and dump per channel, 0 is I and 1 is Q: also the image lowpass
  for (genvar ch = 0; ch < 2; ch++) begin : g_acc
    logic signed [AW-1:0] acc;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc <= '0;
      end else if (run) begin
        if (dump) begin
          acc <= '0;
        end else begin
          acc <= acc + AW'(mix[ch]);
        end
      end
    end

    assign total[ch] = acc + AW'(mix[ch]);
  end

  assign dump_data.i = total[0];
  assign dump_data.q = total[1];

  // result buffer so a slow consumer loses no dump
  ddc_fifo #(
    .WIDTH ($bits(ddc_pkg::ddc_bb_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (dump && ce),
    .in_ready  (fifo_ready),
    .in_data   (dump_data),
    .out_valid (fifo_valid),
    .out_ready (baseband_ready),
    .out_data  (fifo_out)
  );

  // one-clock strobe per result pair handed on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseband_sample_strobe <= 1'b0;
    end else if (ce) begin
      baseband_sample_strobe <= fifo_valid && baseband_ready;
    end
  end

  // result pair held until the next strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseband_sample <= '0;
    end else if (ce && fifo_valid && baseband_ready) begin
      baseband_sample <= fifo_out;
    end
  end
endmodule : ddc_downconverter

// [ddc_adc_model.sv]
`timescale 1ns/1ps
module ddc_adc_model (
  input  wire logic       offset_bin,
  input  wire logic       quad,
  input  wire logic [7:0] level,
  output logic      [7:0] i_out,
  output logic      [7:0] q_out
);
  // level recoded to the converter format
  assign i_out = level ^ {offset_bin, 7'h00}; // dc levels, low-side IF
  assign q_out = quad ? i_out : {offset_bin, 7'h00};
endmodule : ddc_adc_model

// [ddc_chk_sva.sv]
`timescale 1ns/1ps
module ddc_chk (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic [ddc_pkg::DEC_W-1:0] decim_count,
  input wire logic                      stall,
  input wire logic                      baseband_sample_strobe,
  input wire logic                      baseband_ready,
  input wire ddc_pkg::ddc_bb_s          baseband_sample
);
  logic [7:0] rc;
  logic [7:0] gap;
  logic [7:0] eff_n;
  assign eff_n = (decim_count == 6'h00) ? 8'h40 :
                 (decim_count == 6'h01) ? 8'h02 : {2'h0, decim_count};
  // cycles of unbroken ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rc <= 8'h00;
    else if (!baseband_ready) rc <= 8'h00;
    else if (rc != 8'hFF) rc <= rc + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap <= 8'h00;
    else if (baseband_sample_strobe) gap <= 8'h01;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_sample_hold:
    assert property (!baseband_sample_strobe |-> $stable(baseband_sample)) else $error("moved");
  chk_strobe_gap:
    assert property (baseband_sample_strobe && rc > 8'h63 |-> gap == eff_n) else $error("gap");
  chk_strobe_pulse:
    assert property (baseband_sample_strobe && rc > 8'h63 |=> !baseband_sample_strobe)
    else $error("pulse");
  chk_strobe_ready:
    assert property (baseband_sample_strobe |-> $past(baseband_ready)) else $error("ready");
  chk_drain_unstalls:
    assert property (rc > 8'h13 |-> !stall) else $error("stall");
  chk_stall_holds:
    assert property (stall && !baseband_ready |=> stall) else $error("stall drop");
  chk_reset_quiet:
    assert property ($past(rst) |-> !baseband_sample_strobe && !stall && baseband_sample == '0)
    else $error("reset");
  cover property (baseband_sample_strobe && rc > 8'h63);
  cover property (stall);
  cover property (baseband_sample_strobe && $past(baseband_sample_strobe));
endmodule : ddc_chk
bind ddc_downconverter ddc_chk u_chk (.clk, .rst, .decim_count, .stall,
  .baseband_sample_strobe, .baseband_ready, .baseband_sample);

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t mismatch", $time); end end
module testbench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               ob = 1'b0;
  logic               rdy = 1'b1;
  logic [5:0]         dec = 6'h02;
  logic               ce = 1'b1;
  logic [31:0]        step = 32'h40000000; // quarter-rate LO
  logic [7:0]         lvl = 8'h00;
  logic [7:0]         i_in;
  logic [7:0]         q_in;
  logic               stall;
  logic               stb;
  ddc_pkg::ddc_mode_e mode = ddc_pkg::ddc_direct_if;
  ddc_pkg::ddc_bb_s   bb;
  int                 fails = 0;
  int                 n_tests = 0;
  int                 cyc = 0;
  always #5 clk = ~clk;
  ddc_adc_model adc (.offset_bin(ob), .quad(mode == ddc_pkg::ddc_quadrature), .level(lvl),
    .i_out(i_in), .q_out(q_in));
  ddc_downconverter dut (.clk(clk), .rst(rst), .ce(ce), .mode(mode), .decim_count(dec),
    .phase_step(step), .if_sample_in_i(i_in), .if_sample_in_q(q_in), .zero_is_offset_binary(ob),
    .stall(stall), .baseband_sample_strobe(stb), .baseband_ready(rdy), .baseband_sample(bb));
  task finish_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task do_reset(input logic [5:0] d);
    @(negedge clk);
    rst = 1'b1;
    dec = d;
    repeat (16) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  task wait_stb;
    int k;
    k = 0;
    @(negedge clk);
    while (!stb && k < 400) begin
      @(negedge clk);
      k++;
    end
    `CHK(stb, 1'b1)
  endtask : wait_stb
  task t_timing;
    logic [5:0] dv [5] = '{6'h02, 6'h03, 6'h3F, 6'h00, 6'h01};
    int ev [5] = '{2, 3, 63, 64, 2};
    int gap;
    for (int t = 0; t < 5; t++) begin
      do_reset(dv[t]);
      wait_stb();
      gap = 0;
      do begin
        @(negedge clk);
        gap++;
      end while (!stb && gap < 100);
      `CHK(gap, ev[t])
    end
    $display("t_timing done");
  endtask : t_timing
  task t_zero;
    for (int m = 0; m < 4; m++) begin
      mode = ddc_pkg::ddc_mode_e'(m[0]);
      ob = m[1];
      lvl = 8'h00;
      do_reset(6'h04);
      repeat (40) @(negedge clk);
      wait_stb();
      `CHK(bb, 48'h0)
    end
    $display("t_zero done");
  endtask : t_zero
  task t_dc;
    int di;
    int dq;
    // phase held at zero: cosine near full scale, sine near zero
    step = 32'h00000000;
    ob = 1'b0;
    lvl = 8'h40;
    mode = ddc_pkg::ddc_direct_if;
    do_reset(6'h04);
    repeat (20) @(negedge clk);
    wait_stb();
    di = bb.i;
    dq = bb.q;
    `CHK(di > 0, 1'b1)
    `CHK(dq >= 0 && dq * 16 < di, 1'b1)
    // equal i and q: four products give i = x(c - s), q = x(c + s)
    mode = ddc_pkg::ddc_quadrature;
    do_reset(6'h04);
    repeat (20) @(negedge clk);
    wait_stb();
    `CHK(int'(bb.i) + int'(bb.q), 2 * di)
    `CHK(int'(bb.q) - int'(bb.i), 2 * dq)
    step = 32'h40000000;
    $display("t_dc done");
  endtask : t_dc
  task t_ce;
    int gap;
    int nstb;
    ddc_pkg::ddc_bb_s held;
    mode = ddc_pkg::ddc_direct_if;
    do_reset(6'h04);
    wait_stb();
    held = bb;
    @(negedge clk);
    ce = 1'b0;
    gap = 1;
    nstb = 0;
    repeat (10) begin
      @(negedge clk);
      gap++;
      if (stb) begin
        nstb++;
      end
    end
    ce = 1'b1;
    `CHK(nstb, 0)
    `CHK(bb, held)
    do begin
      @(negedge clk);
      gap++;
    end while (!stb && gap < 100);
    `CHK(gap, 4 + 10)
    $display("t_ce done");
  endtask : t_ce
  task t_fifo;
    int k;
    int cnt;
    mode = ddc_pkg::ddc_direct_if;
    lvl = 8'h10;
    do_reset(6'h02);
    rdy = 1'b0;
    k = 0;
    while (!stall && k < 200) begin
      @(negedge clk);
      k++;
    end
    `CHK(stall, 1'b1)
    rdy = 1'b1;
    cnt = 0;
    repeat (20) begin
      @(negedge clk);
      if (stb) cnt++;
    end
    `CHK(cnt >= 16, 1'b1)
    `CHK(stall, 1'b0)
    $display("t_fifo done");
  endtask : t_fifo
  initial begin
    do_reset(6'h02);
    t_timing();
    t_zero();
    t_dc();
    t_ce();
    t_fifo();
    finish_test();
  end
endmodule : testbench
